// [bvr_boost_limiter.sv]
/*
 * Per-boost voltage request stage: picks the fixed initial code or the
 * loop's tracking code and clamps it to the configured ceiling.
 * Assumes the loop request arrives from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module bvr_boost_limiter (
    input wire logic mclk, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire bvr_pkg::bvr_boost_cfg_type cfg, // Stored voltage settings
    input wire logic [4:0] loop_code, // Code wanted by the boost loop
    output logic [4:0] target_code, // Code sent to the boost loop
    output logic [15:0] target_mv, // Requested voltage in millivolts
    output logic [15:0] ceiling_mv // Decoded ceiling in millivolts
);

    logic [4:0] ceil_code;
    logic [4:0] wanted_code;
    logic [4:0] next_code;

    assign ceil_code = bvr_pkg::CEILING_CODE[cfg.boost_voltage_ceiling];

    always_comb begin
        if (cfg.headroom_tracking_enable) begin
            wanted_code = loop_code;
        end else begin
            wanted_code = cfg.initial_boost_code;
        end
        // Clamp applies to the fixed code too, so no setting exceeds it
        if (wanted_code > ceil_code) begin
            next_code = ceil_code;
        end else begin
            next_code = wanted_code;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            target_code <= 5'h00;
            target_mv <= bvr_pkg::FLOOR_MV;
            ceiling_mv <= bvr_pkg::CEILING_MV[0];
        end else begin
            target_code <= next_code;
            target_mv <= bvr_pkg::CODE_MV[next_code];
            ceiling_mv <= bvr_pkg::CEILING_MV[cfg.boost_voltage_ceiling];
        end
    end

    a_request_under_ceiling: assert property (
        @(posedge mclk) disable iff (!rst_b)
        $past(rst_b) |->
        (target_mv <= ceiling_mv && target_mv >= bvr_pkg::FLOOR_MV))
    else $error("boost request outside floor or ceiling");

    a_fixed_initial_code: assert property (
        @(posedge mclk) disable iff (!rst_b)
        !cfg.headroom_tracking_enable && cfg.initial_boost_code <= ceil_code
        |=> target_code == $past(cfg.initial_boost_code))
    else $error("fixed mode did not hold the initial code");

endmodule : bvr_boost_limiter

`default_nettype wire

// [bvr_boost_voltage_regs.sv]
/*
 * Boost voltage, bank B string enable and identifier register bank with
 * the string gating and the two boost request limiters.
 * Assumes a byte-wide register port driven on mclk, fault flags from
 * analog comparators (asynchronous) and a nonvolatile identifier word
 * that is valid when reset is released.
 */
`timescale 1ns/1ps
`default_nettype none

module bvr_boost_voltage_regs #(
    parameter logic [3:0] MAJOR_REV = 4'h1, // Arbitrary value
    parameter logic [3:0] MINOR_REV = 4'h0, // Arbitrary value
    parameter logic [3:0] VARIANT_CODE = 4'h5 // Arbitrary value
) (
    input wire logic mclk, // System clock, 100 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input wire bvr_pkg::bvr_reg_req_type reg_req, // Register access
    output logic [7:0] reg_rdata, // Read data, one cycle after rd
    output logic reg_rvalid, // Read data valid pulse
    input wire logic [7:0] nv_id_codes, // Factory identifier word
    input wire logic auto_fault_removal, // Drop faulty strings when 1
    input wire logic backlight_on, // Backlight running
    input wire logic [5:0] string_open, // Open flags, asynchronous
    input wire logic [5:0] string_short, // Short flags, asynchronous
    input wire logic [4:0] boost_a_loop_code, // Boost A loop request
    input wire logic [4:0] boost_b_loop_code, // Boost B loop request
    output bvr_pkg::bvr_boost_cfg_type boost_a_cfg, // Boost A settings
    output bvr_pkg::bvr_boost_cfg_type boost_b_cfg, // Boost B settings
    output logic [4:0] boost_a_target_code, // Boost A request code
    output logic [15:0] boost_a_target_mv, // Boost A request voltage
    output logic [4:0] boost_b_target_code, // Boost B request code
    output logic [15:0] boost_b_target_mv, // Boost B request voltage
    output logic [5:0] bank_b_string_enables, // Stored string enables
    output logic [5:0] bank_b_string_active, // String drivers on
    output logic [5:0] bank_b_string_removed // Strings dropped by fault
);

    bvr_pkg::bvr_ident_type identifier_codes;
    logic [7:0] spare_user_byte;
    logic id_loaded;
    logic [7:0] next_rdata;
    logic [5:0] open_meta;
    logic [5:0] open_sync;
    logic [5:0] short_meta;
    logic [5:0] short_sync;
    logic [5:0] fault_now;
    logic [5:0] next_active;
    logic [5:0] next_removed;
    logic [15:0] boost_a_ceiling_mv;
    logic [15:0] boost_b_ceiling_mv;
    logic wr_boost_a;
    logic wr_boost_b;
    logic wr_bank_b;
    logic wr_spare;
    logic wr_ident;

    assign wr_boost_a = reg_req.wr && reg_req.addr == bvr_pkg::ADDR_BOOST_A;
    assign wr_boost_b = reg_req.wr && reg_req.addr == bvr_pkg::ADDR_BOOST_B;
    assign wr_bank_b = reg_req.wr && reg_req.addr == bvr_pkg::ADDR_BANK_B;
    assign wr_spare = reg_req.wr && reg_req.addr == bvr_pkg::ADDR_SPARE;
    assign wr_ident = reg_req.wr && reg_req.addr == bvr_pkg::ADDR_IDENT;

    // Boost voltage settings, one register per boost
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            boost_a_cfg <= bvr_pkg::BOOST_CFG_RESET;
        end else if (wr_boost_a) begin
            boost_a_cfg <= reg_req.wdata;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            boost_b_cfg <= bvr_pkg::BOOST_CFG_RESET;
        end else if (wr_boost_b) begin
            boost_b_cfg <= reg_req.wdata;
        end
    end

    // Only the enable field is stored; bits 7:6 have no storage
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bank_b_string_enables <= bvr_pkg::STRING_ENABLE_RESET;
        end else if (wr_bank_b) begin
            bank_b_string_enables <= reg_req.wdata[5:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            spare_user_byte <= bvr_pkg::SPARE_RESET;
        end else if (wr_spare) begin
            spare_user_byte <= reg_req.wdata;
        end
    end

    // Storage word is caught on the first edge after release, never in
    // reset, so a late-settling storage read is still picked up.
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            id_loaded <= 1'b0;
            identifier_codes <= bvr_pkg::IDENT_RESET;
        end else begin
            id_loaded <= 1'b1;
            if (!id_loaded) begin
                identifier_codes <= nv_id_codes;
            end else if (wr_ident) begin
                identifier_codes <= reg_req.wdata;
            end
        end
    end

    // Read mux; revision and variant have no storage to write
    always_comb begin
        next_rdata = bvr_pkg::READ_UNMAPPED;
        case (reg_req.addr)
            bvr_pkg::ADDR_IDENT: next_rdata = identifier_codes;
            bvr_pkg::ADDR_REVISION: next_rdata = {MAJOR_REV, MINOR_REV};
            bvr_pkg::ADDR_BOOST_A: next_rdata = boost_a_cfg;
            bvr_pkg::ADDR_BANK_B: begin
                next_rdata = {bvr_pkg::BANK_B_RESERVED,
                              bank_b_string_enables};
            end
            bvr_pkg::ADDR_BOOST_B: next_rdata = boost_b_cfg;
            bvr_pkg::ADDR_VARIANT: begin
                next_rdata = {bvr_pkg::VARIANT_RESERVED, VARIANT_CODE};
            end
            bvr_pkg::ADDR_SPARE: next_rdata = spare_user_byte;
            default: next_rdata = bvr_pkg::READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            reg_rvalid <= 1'b0;
            reg_rdata <= bvr_pkg::READ_UNMAPPED;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                reg_rdata <= next_rdata;
            end
        end
    end

    // Fault comparators are asynchronous to mclk
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            open_meta <= 6'h00;
            open_sync <= 6'h00;
            short_meta <= 6'h00;
            short_sync <= 6'h00;
        end else begin
            open_meta <= string_open;
            open_sync <= open_meta;
            short_meta <= string_short;
            short_sync <= short_meta;
        end
    end

    assign fault_now = open_sync | short_sync;

    // Removal is latched until the backlight goes off, so a string that
    // faulted cannot flicker back on when the fault flag chatters.
    genvar gi;
    generate
        for (gi = 0; gi < bvr_pkg::STRING_COUNT; gi++) begin : g_string
            always_comb begin
                next_removed[gi] = bank_b_string_removed[gi];
                if (!backlight_on) begin
                    next_removed[gi] = 1'b0;
                end
                if (auto_fault_removal && backlight_on &&
                    bank_b_string_enables[gi] && fault_now[gi]) begin
                    next_removed[gi] = 1'b1;
                end
                next_active[gi] = bank_b_string_enables[gi] &&
                                  backlight_on;
                if (auto_fault_removal &&
                    (bank_b_string_removed[gi] || fault_now[gi])) begin
                    next_active[gi] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bank_b_string_removed <= 6'h00;
            bank_b_string_active <= 6'h00;
        end else begin
            bank_b_string_removed <= next_removed;
            bank_b_string_active <= next_active;
        end
    end

    bvr_boost_limiter u_boost_a (
        .mclk(mclk),
        .rst_b(rst_b),
        .cfg(boost_a_cfg),
        .loop_code(boost_a_loop_code),
        .target_code(boost_a_target_code),
        .target_mv(boost_a_target_mv),
        .ceiling_mv(boost_a_ceiling_mv)
    );

    bvr_boost_limiter u_boost_b (
        .mclk(mclk),
        .rst_b(rst_b),
        .cfg(boost_b_cfg),
        .loop_code(boost_b_loop_code),
        .target_code(boost_b_target_code),
        .target_mv(boost_b_target_mv),
        .ceiling_mv(boost_b_ceiling_mv)
    );

    sequence s_spare_write;
        reg_req.wr && reg_req.addr == bvr_pkg::ADDR_SPARE;
    endsequence

    sequence s_spare_read;
        reg_req.rd && !reg_req.wr && reg_req.addr == bvr_pkg::ADDR_SPARE;
    endsequence

    a_disabled_stays_dark: assert property (
        @(posedge mclk) disable iff (!rst_b)
        $past(rst_b) |->
        (bank_b_string_active & ~$past(bank_b_string_enables)) == 6'h00)
    else $error("disabled string was driven");

    a_manual_strings_on: assert property (
        @(posedge mclk) disable iff (!rst_b)
        !auto_fault_removal && backlight_on
        |=> bank_b_string_active == $past(bank_b_string_enables))
    else $error("enabled string not active with auto removal off");

    a_fault_drops_string: assert property (
        @(posedge mclk) disable iff (!rst_b)
        auto_fault_removal && backlight_on &&
        (fault_now & bank_b_string_enables) != 6'h00
        |=> ((bank_b_string_active | ~bank_b_string_removed) &
             $past(fault_now & bank_b_string_enables)) == 6'h00)
    else $error("faulty string not removed");

    a_spare_read_back: assert property (
        @(posedge mclk) disable iff (!rst_b)
        s_spare_write ##1 s_spare_read
        |=> reg_rvalid && reg_rdata == $past(reg_req.wdata, 2))
    else $error("spare byte did not read back");

    a_revision_fixed: assert property (
        @(posedge mclk) disable iff (!rst_b)
        reg_req.rd && reg_req.addr == bvr_pkg::ADDR_REVISION
        |=> reg_rvalid && reg_rdata == {MAJOR_REV, MINOR_REV})
    else $error("revision read wrong");

    a_variant_reserved: assert property (
        @(posedge mclk) disable iff (!rst_b)
        reg_req.rd && reg_req.addr == bvr_pkg::ADDR_VARIANT
        |=> reg_rdata == {bvr_pkg::VARIANT_RESERVED, VARIANT_CODE})
    else $error("variant register changed");

    a_bank_b_reserved: assert property (
        @(posedge mclk) disable iff (!rst_b)
        reg_req.rd && reg_req.addr == bvr_pkg::ADDR_BANK_B
        |=> reg_rdata[7:6] == bvr_pkg::BANK_B_RESERVED &&
            reg_rdata[5:0] == $past(bank_b_string_enables))
    else $error("bank B enable read wrong");

    a_ident_from_storage: assert property (
        @(posedge mclk) disable iff (!rst_b)
        !id_loaded |=> identifier_codes == $past(nv_id_codes))
    else $error("identifier not loaded from storage");

    a_boost_b_layout: assert property (
        @(posedge mclk) disable iff (!rst_b)
        wr_boost_b && !wr_boost_a
        |=> boost_b_cfg == $past(reg_req.wdata) &&
            boost_a_cfg == $past(boost_a_cfg))
    else $error("boost B register not independent");

endmodule : bvr_boost_voltage_regs

`default_nettype wire

// [bvr_boost_voltage_regs_tb.sv]
/*
 * Self-checking bench for the boost voltage and identifier register bank:
 * register access, boost request clamping and bank B string gating.
 * Assumes the byte strobe port and timing described in the design notes.
 */
`timescale 1ns/1ps
`default_nettype none

module bvr_boost_voltage_regs_tb;
    logic mclk;
    logic rst_b;
    bvr_pkg::bvr_reg_req_type req;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] nv_id;
    logic auto_rm;
    logic bl_on;
    logic [5:0] s_open;
    logic [5:0] s_short;
    logic [4:0] loop_a;
    logic [4:0] loop_b;
    bvr_pkg::bvr_boost_cfg_type cfg_a;
    bvr_pkg::bvr_boost_cfg_type cfg_b;
    logic [4:0] tcode_a;
    logic [4:0] tcode_b;
    logic [15:0] tmv_a;
    logic [15:0] tmv_b;
    logic [5:0] en;
    logic [5:0] act;
    logic [5:0] rem;
    int err_count;
    int tests_run;

    // Revision and variant values are arbitrary
    bvr_boost_voltage_regs #(.MAJOR_REV(4'h3), .MINOR_REV(4'h7),
        .VARIANT_CODE(4'hA)) i_dut (
        .mclk(mclk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .nv_id_codes(nv_id),
        .auto_fault_removal(auto_rm), .backlight_on(bl_on),
        .string_open(s_open), .string_short(s_short),
        .boost_a_loop_code(loop_a), .boost_b_loop_code(loop_b),
        .boost_a_cfg(cfg_a), .boost_b_cfg(cfg_b),
        .boost_a_target_code(tcode_a), .boost_a_target_mv(tmv_a),
        .boost_b_target_code(tcode_b), .boost_b_target_mv(tmv_b),
        .bank_b_string_enables(en), .bank_b_string_active(act),
        .bank_b_string_removed(rem));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic give_verdict();
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Highest code whose table voltage stays within the ceiling
    function automatic logic [4:0] ceil_code(input logic [1:0] c);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (bvr_pkg::CODE_MV[i] <= bvr_pkg::CEILING_MV[c]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : ceil_code

    function automatic logic [4:0] exp_code(
        input bvr_pkg::bvr_boost_cfg_type c, input logic [4:0] lc);
        logic [4:0] want;
        want = c.headroom_tracking_enable ? lc : c.initial_boost_code;
        if (want > ceil_code(c.boost_voltage_ceiling)) begin
            want = ceil_code(c.boost_voltage_ceiling);
        end
        return want;
    endfunction : exp_code

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge mclk);
        req.wr = 1'b0;
    endtask : reg_wr

    // Called at a falling edge, so a read may follow a write back to back;
    // read data taken only while the valid pulse stands
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge mclk);
        req.rd = 1'b0;
        d = (rvalid === 1'b1) ? rdata : 8'hXX;
        @(negedge mclk);
    endtask : reg_rd

    task automatic boost_run(input bit b, input bvr_pkg::bvr_boost_cfg_type c,
                             input logic [4:0] lc);
        logic [7:0] d;
        logic [4:0] ec;
        bvr_pkg::bvr_boost_cfg_type other;
        other = b ? cfg_a : cfg_b;
        if (b) loop_b = lc;
        else loop_a = lc;
        reg_wr(b ? bvr_pkg::ADDR_BOOST_B : bvr_pkg::ADDR_BOOST_A, c);
        repeat (2) @(negedge mclk);
        ec = exp_code(c, lc);
        check("target_code", 16'(b ? tcode_b : tcode_a), 16'(ec));
        check("target_mv", b ? tmv_b : tmv_a, bvr_pkg::CODE_MV[ec]);
        check("other_cfg", 16'(b ? cfg_a : cfg_b), 16'(other));
        check("own_cfg", 16'(b ? cfg_b : cfg_a), 16'(c));
        reg_rd(b ? bvr_pkg::ADDR_BOOST_B : bvr_pkg::ADDR_BOOST_A, d);
        check("boost_readback", 16'(d), 16'(c));
    endtask : boost_run

    initial begin
        logic [7:0] d;
        logic [7:0] w;
        logic [5:0] bit_sel;
        err_count = 0;
        tests_run = 0;
        void'($urandom(23116));
        req = '0;
        rst_b = 1'b0;
        nv_id = 8'($urandom);
        auto_rm = 1'b0;
        bl_on = 1'b0;
        s_open = 6'h00;
        s_short = 6'h00;
        loop_a = 5'h00;
        loop_b = 5'h00;
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        @(negedge mclk);
        reg_rd(bvr_pkg::ADDR_IDENT, d);
        check("ident", 16'(d), 16'(nv_id));
        w = 8'($urandom);
        reg_wr(bvr_pkg::ADDR_IDENT, w);
        reg_rd(bvr_pkg::ADDR_IDENT, d);
        check("ident_write", 16'(d), 16'(w));
        for (int k = 0; k < 2; k++) begin
            reg_rd(bvr_pkg::ADDR_REVISION, d);
            check("revision", 16'(d), 16'h0037);
            reg_rd(bvr_pkg::ADDR_VARIANT, d);
            check("variant", 16'(d), 16'h000A);
            reg_wr(bvr_pkg::ADDR_REVISION, 8'($urandom));
            reg_wr(bvr_pkg::ADDR_VARIANT, 8'($urandom));
        end
        reg_rd(8'h20, d);
        check("unmapped", 16'(d), 16'(bvr_pkg::READ_UNMAPPED));
        for (int k = 0; k < 4; k++) begin
            w = (k == 0) ? 8'hFF : 8'($urandom);
            reg_wr(bvr_pkg::ADDR_SPARE, w);
            reg_rd(bvr_pkg::ADDR_SPARE, d);
            check("spare", 16'(d), 16'(w));
        end
        // Every ceiling, both modes, both boosts; even passes push code 31
        for (int c = 0; c < 4; c++) begin
            for (int t = 0; t < 2; t++) begin
                for (int b = 0; b < 2; b++) begin
                    w = {2'(c), 1'(t), 5'($urandom)};
                    if (b == 0) w[4:0] = 5'h1F;
                    boost_run(1'(b), w, (b == 0) ? 5'h1F : 5'($urandom));
                end
            end
        end
        reg_wr(bvr_pkg::ADDR_BANK_B, 8'hFF);
        reg_rd(bvr_pkg::ADDR_BANK_B, d);
        check("bank_b_reserved", 16'(d), 16'h003F);
        for (int k = 0; k < 3; k++) begin
            w = 8'($urandom);
            reg_wr(bvr_pkg::ADDR_BANK_B, w);
            bl_on = 1'b1;
            auto_rm = 1'b0;
            repeat (2) @(negedge mclk);
            check("enables", 16'(en), 16'(w[5:0]));
            check("active", 16'(act), 16'(w[5:0]));
            s_open = 6'h3F;
            repeat (4) @(negedge mclk);
            check("active_fault", 16'(act), 16'(w[5:0]));
            auto_rm = 1'b1;
            repeat (2) @(negedge mclk);
            check("active_auto", 16'(act), 16'h0000);
            check("removed", 16'(rem), 16'(w[5:0]));
            s_open = 6'h00;
            bl_on = 1'b0;
            repeat (2) @(negedge mclk);
            check("active_off", 16'(act), 16'h0000);
            bl_on = 1'b1;
            bit_sel = 6'h01 << ($urandom % 6);
            s_short = bit_sel;
            repeat (5) @(negedge mclk);
            check("active_short", 16'(act), 16'(w[5:0] & ~bit_sel));
            s_short = 6'h00;
            bl_on = 1'b0;
            repeat (2) @(negedge mclk);
        end
        give_verdict();
    end

    initial begin
        #500us;
        err_count++;
        give_verdict();
    end
endmodule : bvr_boost_voltage_regs_tb

`default_nettype wire

// [bvr_pkg.sv]
/*
 * Shared definitions for the boost voltage and identifier register bank:
 * register offsets, field layouts, reset values, voltage lookup tables.
 * Assumes every user refers to these names as bvr_pkg::name.
 */
`default_nettype none

package bvr_pkg;

    // Register offsets on the byte-wide register port
    localparam logic [7:0] ADDR_IDENT = 8'h0E;
    localparam logic [7:0] ADDR_REVISION = 8'h0F;
    localparam logic [7:0] ADDR_BOOST_A = 8'h16;
    localparam logic [7:0] ADDR_BANK_B = 8'h19;
    localparam logic [7:0] ADDR_BOOST_B = 8'h1A;
    localparam logic [7:0] ADDR_VARIANT = 8'h1C;
    localparam logic [7:0] ADDR_SPARE = 8'h1D;

    localparam int STRING_COUNT = 6;
    localparam int CODE_WIDTH = 5;
    localparam int MV_WIDTH = 16;

    // Bits 7:6 ceiling, bit 5 tracking enable, bits 4:0 initial code
    typedef struct packed {
        logic [1:0] boost_voltage_ceiling;
        logic headroom_tracking_enable;
        logic [4:0] initial_boost_code;
    } bvr_boost_cfg_type;

    // Identifier: customer code in 7:4, configuration code in 3:0
    typedef struct packed {
        logic [3:0] customer_code;
        logic [3:0] configuration_code;
    } bvr_ident_type;

    // One register access per cycle; rd and wr are one-cycle strobes
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bvr_reg_req_type;

    localparam bvr_boost_cfg_type BOOST_CFG_RESET = 8'h00;
    localparam logic [5:0] STRING_ENABLE_RESET = 6'h00;
    localparam logic [7:0] SPARE_RESET = 8'h00;
    localparam bvr_ident_type IDENT_RESET = 8'h00;
    localparam logic [1:0] BANK_B_RESERVED = 2'h0;
    localparam logic [3:0] VARIANT_RESERVED = 4'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // Boost voltage per initial code, in millivolts, code 0 first
    localparam logic [15:0] CODE_MV [0:31] = '{
        16'h1B58, 16'h1E00, 16'h209E, 16'h2346, 16'h25EE, 16'h2896,
        16'h2B34, 16'h2DDC, 16'h3084, 16'h3322, 16'h35CA, 16'h3872,
        16'h3B1A, 16'h3DB8, 16'h4060, 16'h4308, 16'h45B0, 16'h4858,
        16'h4B00, 16'h4D9E, 16'h5046, 16'h52EE, 16'h5596, 16'h5834,
        16'h5ADC, 16'h5D84, 16'h6022, 16'h62CA, 16'h6572, 16'h681A,
        16'h6AB8, 16'h6D60
    };

    // Ceiling voltage per ceiling code: 18 V, 22 V, 25 V, 28 V
    localparam logic [15:0] CEILING_MV [0:3] = '{
        16'h4650, 16'h55F0, 16'h61A8, 16'h6D60
    };

    // Highest initial code whose voltage does not pass each ceiling
    localparam logic [4:0] CEILING_CODE [0:3] = '{
        5'h10, 5'h16, 5'h1A, 5'h1F
    };

    // Floor of the tracking range, 7 V
    localparam logic [15:0] FLOOR_MV = 16'h1B58;

endpackage : bvr_pkg

`default_nettype wire
